// ### rtl/fdr_regs.sv
// fan duty and adaptive floor register bank
// assumes reading/limit values are synchronous to i_ref_clk; thermal pin is async
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - duty registers map linearly, 0x00 is 0 percent, 0xFF full high time
// RULE2 - duty registers reset to 0xFF so fans start at full duty
// RULE3 - in automatic mode duty registers follow the live loop duty
// RULE4 - duty reads return 0x00 while that fan is starting up
// RULE5 - in software mode a duty write sets that drive output directly
// RULE6 - three target temperature registers reset to 0x64, 100 degrees
// RULE7 - adaptive enabled channel uses its target register as regulation point
// RULE8 - lock bit set makes target registers read-only, writes dropped
// RULE9 - lock bit set makes control register read-only; it resets to 0x00
// RULE10 - control bit 0 is msb of remote b adjustment interval code
// RULE11 - hold bit with core supply under low limit sets status bit, alert
// RULE12 - during undervoltage disable hot monitor, adaptive control and shutdown entry
// RULE13 - bit 2 captures remote a temperature on thermal pin assertion
// RULE14 - bit 3 captures local temperature on thermal pin assertion
// RULE15 - bit 4 captures remote b temperature on thermal pin assertion
// RULE16 - capture bit clear ignores thermal pin, keeps programmed target
// RULE17 - bits 5..7 enable adaptive start temperature per channel
// RULE18 - adaptive bit clear leaves programmed start temperature untouched
// RULE19 - captured values keep two's-complement reading format
// RULE20 - thermal assertion captured once per assertion edge
module fdr_regs
	import fdr_pkg::*;
(
	// clock and reset
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_arst_n,
	// register port
	input  wire logic [FDR_AW-1:0]    i_addr,
	input  wire logic [FDR_DW-1:0]    i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [FDR_DW-1:0]    o_rdata,
	// configuration lock
	input  wire logic                 i_cfg_lock,
	// fan loop
	input  wire logic                 i_auto_mode,
	input  wire logic [2:0]           i_startup,
	input  wire logic [FDR_DW-1:0]    i_auto_duty_a,
	input  wire logic [FDR_DW-1:0]    i_auto_duty_b,
	input  wire logic [FDR_DW-1:0]    i_auto_duty_c,
	output logic      [FDR_DW-1:0]    o_fan_drive_a,
	output logic      [FDR_DW-1:0]    o_fan_drive_b,
	output logic      [FDR_DW-1:0]    o_fan_drive_c,
	// temperatures and supply
	input  wire logic [FDR_DW-1:0]    i_temp_remote_a,
	input  wire logic [FDR_DW-1:0]    i_temp_local,
	input  wire logic [FDR_DW-1:0]    i_temp_remote_b,
	input  wire logic [FDR_DW-1:0]    i_core_supply,
	input  wire logic [FDR_DW-1:0]    i_core_supply_low_lim,
	input  wire logic                 i_alert_en,
	input  wire logic                 i_thermal_assert_pin,
	// adaptive control outputs
	output logic      [2:0]           o_adaptive_en,
	output logic      [FDR_DW-1:0]    o_target_remote_a,
	output logic      [FDR_DW-1:0]    o_target_local,
	output logic      [FDR_DW-1:0]    o_target_remote_b,
	output logic                      o_cycle_msb_remote_b,
	output logic                      o_uv_status,
	output logic                      o_alert,
	output logic                      o_cpu_hot_monitor_en,
	output logic                      o_shutdown_allow
);
	typedef struct packed {
		logic [7:0] duty_a;
		logic [7:0] duty_b;
		logic [7:0] duty_c;
		logic [7:0] tgt_ra;
		logic [7:0] tgt_loc;
		logic [7:0] tgt_rb;
		logic [7:0] ctrl1;
		logic [7:0] rdata;
		logic [2:0] pin_sync;
		logic       pin_state;
		logic       uv;
	} fdr_state_t;

	fdr_state_t st;
	fdr_state_t next_st;

	logic hot_edge;
	logic uv_now;
	logic wr_ok;

	always_comb begin
		next_st = st;
		wr_ok = i_wr && !i_cfg_lock;
		next_st.pin_sync = {st.pin_sync[1:0], i_thermal_assert_pin};
		// change counts only once second and third stages agree
		hot_edge = 1'b0;
		if (st.pin_sync[1] == st.pin_sync[2]) begin
			next_st.pin_state = st.pin_sync[2];
			hot_edge = st.pin_sync[2] && !st.pin_state; // [RULE20]
		end
		uv_now = st.ctrl1[FDR_B_UV_HOLD] && (i_core_supply < i_core_supply_low_lim); // [RULE11]
		next_st.uv = uv_now;
		// duty: auto loop owns the register, software write only outside auto
		if (i_auto_mode) begin
			next_st.duty_a = i_auto_duty_a; // [RULE3]
			next_st.duty_b = i_auto_duty_b;
			next_st.duty_c = i_auto_duty_c;
		end else if (i_wr) begin
			if (i_addr == FDR_OFS_DUTY_A) next_st.duty_a = i_wdata; // [RULE5]
			if (i_addr == FDR_OFS_DUTY_B) next_st.duty_b = i_wdata;
			if (i_addr == FDR_OFS_DUTY_C) next_st.duty_c = i_wdata;
		end
		// locked writes dropped silently
		if (wr_ok && i_addr == FDR_OFS_TGT_RA) next_st.tgt_ra = i_wdata; // [RULE8]
		if (wr_ok && i_addr == FDR_OFS_TGT_LOC) next_st.tgt_loc = i_wdata;
		if (wr_ok && i_addr == FDR_OFS_TGT_RB) next_st.tgt_rb = i_wdata;
		if (wr_ok && i_addr == FDR_OFS_CTRL1) next_st.ctrl1 = i_wdata; // [RULE9]
		// capture wins over a same-cycle host write; raw two's-complement copy
		if (hot_edge && st.ctrl1[FDR_B_CAP_RA]) next_st.tgt_ra = i_temp_remote_a; // [RULE13] [RULE19]
		if (hot_edge && st.ctrl1[FDR_B_CAP_LOC]) next_st.tgt_loc = i_temp_local; // [RULE14]
		if (hot_edge && st.ctrl1[FDR_B_CAP_RB]) next_st.tgt_rb = i_temp_remote_b; // [RULE15] [RULE16]
		next_st.rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				FDR_OFS_DUTY_A:  next_st.rdata = i_startup[0] ? FDR_DUTY_STARTUP : st.duty_a; // [RULE4]
				FDR_OFS_DUTY_B:  next_st.rdata = i_startup[1] ? FDR_DUTY_STARTUP : st.duty_b;
				FDR_OFS_DUTY_C:  next_st.rdata = i_startup[2] ? FDR_DUTY_STARTUP : st.duty_c;
				FDR_OFS_TGT_RA:  next_st.rdata = st.tgt_ra;
				FDR_OFS_TGT_LOC: next_st.rdata = st.tgt_loc;
				FDR_OFS_TGT_RB:  next_st.rdata = st.tgt_rb;
				FDR_OFS_CTRL1:   next_st.rdata = st.ctrl1;
				default:         next_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st.duty_a    <= FDR_RST_DUTY; // [RULE2]
			st.duty_b    <= FDR_RST_DUTY;
			st.duty_c    <= FDR_RST_DUTY;
			st.tgt_ra    <= FDR_RST_TGT; // [RULE6]
			st.tgt_loc   <= FDR_RST_TGT;
			st.tgt_rb    <= FDR_RST_TGT;
			st.ctrl1     <= FDR_RST_CTRL1;
			st.rdata     <= 8'h00;
			st.pin_sync  <= 3'h0;
			st.pin_state <= 1'b0;
			st.uv        <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// duty code drives output linearly
	assign o_fan_drive_a = st.duty_a; // [RULE1]
	assign o_fan_drive_b = st.duty_b;
	assign o_fan_drive_c = st.duty_c;
	assign o_rdata = st.rdata;
	// undervoltage suspends adaptive floor, hot monitor and shutdown
	assign o_adaptive_en = st.uv ? 3'h0 : {st.ctrl1[FDR_B_ADP_RB], st.ctrl1[FDR_B_ADP_LOC],
		st.ctrl1[FDR_B_ADP_RA]}; // [RULE12] [RULE17] [RULE18]
	assign o_target_remote_a = st.tgt_ra; // [RULE7]
	assign o_target_local = st.tgt_loc;
	assign o_target_remote_b = st.tgt_rb;
	assign o_cycle_msb_remote_b = st.ctrl1[FDR_B_CYC_MSB]; // [RULE10]
	assign o_uv_status = st.uv;
	assign o_alert = st.uv && i_alert_en;
	assign o_cpu_hot_monitor_en = !st.uv;
	assign o_shutdown_allow = !st.uv;

	a_duty_reset: assert property (@(posedge i_ref_clk) $rose(i_arst_n) |-> st.duty_a == FDR_RST_DUTY) // [RULE2]
		else $error("duty not at reset value");
	a_auto_follow: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_auto_mode |=> o_fan_drive_a == $past(i_auto_duty_a)) // [RULE3]
		else $error("duty does not follow loop");
	a_startup_read: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_rd && i_addr == FDR_OFS_DUTY_A && i_startup[0]) |=> o_rdata == 8'h00) // [RULE4]
		else $error("startup read not zero");
	a_sw_write: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(!i_auto_mode && i_wr && i_addr == FDR_OFS_DUTY_B) |=> o_fan_drive_b == $past(i_wdata)) // [RULE5]
		else $error("software duty write lost");
	a_lock_target: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_cfg_lock && !hot_edge) |=> $stable(st.tgt_loc)) // [RULE8]
		else $error("locked target changed");
	a_lock_ctrl: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_cfg_lock |=> $stable(st.ctrl1)) // [RULE9]
		else $error("locked control changed");
	a_uv_block: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_uv_status |-> (o_adaptive_en == 3'h0 && !o_shutdown_allow && !o_cpu_hot_monitor_en)) // [RULE12]
		else $error("undervoltage not blocking");
	a_capture_ra: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(hot_edge && st.ctrl1[FDR_B_CAP_RA]) |=> st.tgt_ra == $past(i_temp_remote_a)) // [RULE13]
		else $error("remote a capture missed");
	a_capture_off: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(hot_edge && !st.ctrl1[FDR_B_CAP_RB] && !i_wr) |=> $stable(st.tgt_rb)) // [RULE16]
		else $error("capture while disabled");
	a_one_edge: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		hot_edge |=> !hot_edge) // [RULE20]
		else $error("thermal edge repeated");
	a_lock_remote_b: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(i_cfg_lock && !hot_edge) |=> $stable(st.tgt_rb)) // [RULE8]
		else $error("locked remote b target changed");
	a_capture_loc: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(hot_edge && st.ctrl1[FDR_B_CAP_LOC]) |=> st.tgt_loc == $past(i_temp_local)) // [RULE14]
		else $error("local capture missed");
	a_capture_rb: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(hot_edge && st.ctrl1[FDR_B_CAP_RB]) |=> st.tgt_rb == $past(i_temp_remote_b)) // [RULE15]
		else $error("remote b capture missed");
	a_uv_detect: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(st.ctrl1[FDR_B_UV_HOLD] && (i_core_supply < i_core_supply_low_lim)) |=> o_uv_status) // [RULE11]
		else $error("undervoltage not flagged");
	a_alert_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		(o_uv_status && i_alert_en) |-> o_alert) // [RULE11]
		else $error("alert missing under undervoltage");
	c_auto_mode: cover property (@(posedge i_ref_clk) i_auto_mode && i_rd && i_addr == FDR_OFS_DUTY_A);
	c_capture: cover property (@(posedge i_ref_clk) hot_edge && st.ctrl1[FDR_B_CAP_LOC]);
	c_uv: cover property (@(posedge i_ref_clk) $rose(o_uv_status));
	c_locked_wr: cover property (@(posedge i_ref_clk) i_cfg_lock && i_wr && i_addr == FDR_OFS_TGT_RA);
endmodule
`default_nettype wire

// ### shared/fdr_pkg.sv
// constants for the fan duty and adaptive floor register bank
// assumes an 8-bit register address space and 8-bit data
package fdr_pkg;
	localparam int          FDR_AW            = 8;
	localparam int          FDR_DW            = 8;
	localparam logic [7:0] FDR_OFS_DUTY_A    = 8'h30;
	localparam logic [7:0] FDR_OFS_DUTY_B    = 8'h31;
	localparam logic [7:0] FDR_OFS_DUTY_C    = 8'h32;
	localparam logic [7:0] FDR_OFS_TGT_RA    = 8'h33;
	localparam logic [7:0] FDR_OFS_TGT_LOC   = 8'h34;
	localparam logic [7:0] FDR_OFS_TGT_RB    = 8'h35;
	localparam logic [7:0] FDR_OFS_CTRL1     = 8'h36;
	localparam logic [7:0] FDR_RST_DUTY      = 8'hFF;
	localparam logic [7:0] FDR_RST_TGT       = 8'h64;
	localparam logic [7:0] FDR_RST_CTRL1     = 8'h00;
	localparam logic [7:0] FDR_DUTY_STARTUP  = 8'h00;
	localparam int          FDR_B_CYC_MSB     = 0;
	localparam int          FDR_B_UV_HOLD     = 1;
	localparam int          FDR_B_CAP_RA      = 2;
	localparam int          FDR_B_CAP_LOC     = 3;
	localparam int          FDR_B_CAP_RB      = 4;
	localparam int          FDR_B_ADP_RA      = 5;
	localparam int          FDR_B_ADP_LOC     = 6;
	localparam int          FDR_B_ADP_RB      = 7;
endpackage

// ### tb/fdr_regs_tb.sv
// self-checking bench for the fan duty and adaptive floor register bank
// assumes fdr_pkg is compiled first; bench alone drives every design input
`timescale 1ns/1ps
`default_nettype none
module fdr_regs_tb;
	import fdr_pkg::*;
	logic       i_ref_clk = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, i_cfg_lock = 0, i_auto_mode = 0;
	logic       i_alert_en = 1, i_thermal_assert_pin = 0, rd_pend = 0;
	logic [7:0] i_addr = 0, i_wdata = 0, i_auto_duty_a = 0, i_auto_duty_b = 0, i_auto_duty_c = 0;
	logic [7:0] i_temp_remote_a = 0, i_temp_local = 0, i_temp_remote_b = 0, i_core_supply = 8'h80;
	logic [7:0] i_core_supply_low_lim = 8'h10, o_rdata, o_fan_drive_a, o_fan_drive_b, o_fan_drive_c;
	logic [7:0] o_target_remote_a, o_target_local, o_target_remote_b, d, r;
	logic [2:0] i_startup = 0, o_adaptive_en;
	logic       o_cycle_msb_remote_b, o_uv_status, o_alert, o_cpu_hot_monitor_en, o_shutdown_allow;
	logic [7:0] exp_q[$];
	int         bad_count = 0, checks = 0, seed = 54832;
	always #2 i_ref_clk = ~i_ref_clk;
	fdr_regs u_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cfg_lock(i_cfg_lock), .i_auto_mode(i_auto_mode),
		.i_startup(i_startup), .i_auto_duty_a(i_auto_duty_a), .i_auto_duty_b(i_auto_duty_b),
		.i_auto_duty_c(i_auto_duty_c), .o_fan_drive_a(o_fan_drive_a), .o_fan_drive_b(o_fan_drive_b),
		.o_fan_drive_c(o_fan_drive_c), .i_temp_remote_a(i_temp_remote_a), .i_temp_local(i_temp_local),
		.i_temp_remote_b(i_temp_remote_b), .i_core_supply(i_core_supply),
		.i_core_supply_low_lim(i_core_supply_low_lim), .i_alert_en(i_alert_en),
		.i_thermal_assert_pin(i_thermal_assert_pin), .o_adaptive_en(o_adaptive_en),
		.o_target_remote_a(o_target_remote_a), .o_target_local(o_target_local),
		.o_target_remote_b(o_target_remote_b), .o_cycle_msb_remote_b(o_cycle_msb_remote_b),
		.o_uv_status(o_uv_status), .o_alert(o_alert), .o_cpu_hot_monitor_en(o_cpu_hot_monitor_en),
		.o_shutdown_allow(o_shutdown_allow));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_ref_clk);
		i_wr <= 1; i_addr <= a; i_wdata <= v;
		@(posedge i_ref_clk);
		i_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_ref_clk);
		i_rd <= 1; i_addr <= a; exp_q.push_back(v);
		@(posedge i_ref_clk);
		i_rd <= 0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
	endtask
	// read data is only valid in the cycle after the strobe
	always @(posedge i_ref_clk) rd_pend <= i_rd;
	always @(negedge i_ref_clk) begin
		if (rd_pend) begin
			r = exp_q.pop_front();
			chk("rdata", r, o_rdata);
		end
	end
	task automatic close_out();
		if (bad_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_arst_n <= 1;
		for (int i = 0; i < 3; i++) rd(8'h30 + 8'(i), FDR_RST_DUTY);
		for (int i = 3; i < 6; i++) rd(8'h30 + 8'(i), FDR_RST_TGT);
		rd(FDR_OFS_CTRL1, FDR_RST_CTRL1);
		rd(8'h37, 8'h00);
		for (int i = 0; i < 3; i++) begin
			d = 8'($random(seed));
			wr(8'h30 + 8'(i), d);
			rd(8'h30 + 8'(i), d);
			settle(1);
			chk("drive", d, i == 0 ? o_fan_drive_a : i == 1 ? o_fan_drive_b : o_fan_drive_c);
		end
		wr(FDR_OFS_DUTY_A, 8'h00);
		rd(FDR_OFS_DUTY_A, 8'h00);
		i_auto_mode <= 1; i_auto_duty_a <= 8'h5A; i_auto_duty_b <= 8'hC3; i_auto_duty_c <= 8'h17;
		wr(FDR_OFS_DUTY_A, 8'h99);
		rd(FDR_OFS_DUTY_A, 8'h5A);
		rd(FDR_OFS_DUTY_C, 8'h17);
		i_startup <= 3'b010;
		rd(FDR_OFS_DUTY_B, FDR_DUTY_STARTUP);
		i_startup <= 3'b000; i_auto_mode <= 0;
		wr(FDR_OFS_CTRL1, 8'hE1);
		wr(FDR_OFS_TGT_RA, 8'h3C);
		rd(FDR_OFS_CTRL1, 8'hE1);
		settle(1);
		chk("adaptive_en", 8'h07, 8'(o_adaptive_en));
		chk("cycle_msb", 8'h01, 8'(o_cycle_msb_remote_b));
		chk("target_ra", 8'h3C, o_target_remote_a);
		chk("target_loc", FDR_RST_TGT, o_target_local);
		chk("target_rb", FDR_RST_TGT, o_target_remote_b);
		// inputs move only on a rising edge
		@(posedge i_ref_clk);
		i_cfg_lock <= 1;
		wr(FDR_OFS_TGT_RA, 8'h11);
		wr(FDR_OFS_TGT_RB, 8'h11);
		wr(FDR_OFS_CTRL1, 8'h00);
		rd(FDR_OFS_TGT_RA, 8'h3C);
		rd(FDR_OFS_TGT_RB, FDR_RST_TGT);
		rd(FDR_OFS_CTRL1, 8'hE1);
		i_cfg_lock <= 0;
		wr(FDR_OFS_CTRL1, 8'h14);
		i_temp_remote_a <= 8'hE6; i_temp_local <= 8'h2A; i_temp_remote_b <= 8'h55;
		settle(1);
		chk("adaptive_off", 8'h00, 8'(o_adaptive_en));
		@(posedge i_ref_clk);
		i_thermal_assert_pin <= 1;
		settle(10);
		chk("target_rb_pin", 8'h55, o_target_remote_b);
		rd(FDR_OFS_TGT_RA, 8'hE6);
		rd(FDR_OFS_TGT_LOC, FDR_RST_TGT);
		rd(FDR_OFS_TGT_RB, 8'h55);
		// pin still high: a new reading must not be copied again
		i_temp_remote_a <= 8'h01;
		settle(10);
		rd(FDR_OFS_TGT_RA, 8'hE6);
		i_thermal_assert_pin <= 0;
		wr(FDR_OFS_CTRL1, 8'hEA);
		i_temp_local <= 8'h33;
		i_thermal_assert_pin <= 1;
		settle(10);
		rd(FDR_OFS_TGT_LOC, 8'h33);
		i_core_supply <= 8'h0F;
		settle(4);
		chk("uv_status", 8'h01, 8'(o_uv_status));
		chk("alert", 8'h01, 8'(o_alert));
		chk("hot_mon", 8'h00, 8'(o_cpu_hot_monitor_en));
		chk("shutdown", 8'h00, 8'(o_shutdown_allow));
		chk("adaptive_uv", 8'h00, 8'(o_adaptive_en));
		@(posedge i_ref_clk);
		i_alert_en <= 0;
		settle(1);
		chk("alert_masked", 8'h00, 8'(o_alert));
		@(posedge i_ref_clk);
		i_core_supply <= 8'h11;
		settle(4);
		chk("uv_clear", 8'h00, 8'(o_uv_status));
		chk("hot_mon_back", 8'h01, 8'(o_cpu_hot_monitor_en));
		chk("target_loc_pin", 8'h33, o_target_local);
		chk("adaptive_back", 8'h07, 8'(o_adaptive_en));
		chk("shutdown_back", 8'h01, 8'(o_shutdown_allow));
		settle(2);
		close_out();
	end
endmodule
`default_nettype wire
